// ### common/cnt_array_pkg.sv
// constants for the programmable counter array core
package cnt_array_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h01;
   localparam logic [7:0] ADDR_PWM = 8'h02;
   localparam logic [7:0] ADDR_CNT_LO = 8'h03;
   localparam logic [7:0] ADDR_CNT_HI = 8'h04;
   localparam logic [4:0] BASE_MMODE = 5'h01;
   localparam logic [4:0] BASE_CMP_LO = 5'h02;
   localparam logic [4:0] BASE_CMP_HI = 5'h03;
   localparam int NUM_MODULES = 6;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_CF = 7;
   localparam int CTRL_RUN = 6;
   localparam int MODE_IDLE = 7;
   localparam int MODE_TB_LSB = 1;
   localparam int MODE_OVF_EN = 0;
   localparam int PWM_ARS = 7;
   localparam int PWM_COV_EN = 6;
   localparam int PWM_CYCLE_OVERFLOW_FLAG = 5;
   localparam int MM_PWM16 = 7;
   localparam int MM_ECOM = 6;
   localparam int MM_RISE = 5;
   localparam int MM_FALL = 4;
   localparam int MM_MATCH = 3;
   localparam int MM_TOGGLE = 2;
   localparam int MM_PULSE = 1;
   localparam int MM_IRQ_EN = 0;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_PWM = 8'h00;
   localparam logic [7:0] RST_MMODE = 8'h00;
   localparam logic [15:0] RST_CNT = 16'h0000;
   // ----------------------------------------
   // timebase selections and divisors
   // ----------------------------------------
   typedef enum logic [2:0] {
      TB_DIV12 = 3'b000,
      TB_DIV4 = 3'b001,
      TB_T0OVF = 3'b010,
      TB_EXTIN = 3'b011,
      TB_SYS = 3'b100,
      TB_OSC8 = 3'b101,
      TB_RES6 = 3'b110,
      TB_RES7 = 3'b111
   } timebase_t;
   localparam int DIV_SYS12 = 12;
   localparam int DIV_SYS4 = 4;
   localparam int DIV_OSC8 = 8;
   localparam logic [15:0] PWM_MASK_11 = 16'h07ff;
endpackage

// ### design/sync_edge.sv
// two-stage synchroniser with two-cycle stability filter and edge pulses
module sync_edge (
   // clock and control
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // raw and filtered signal
   input wire logic raw_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_reg, s2_reg, s3_reg, level_reg;
   wire logic stable = (s2_reg == s3_reg);
   wire logic level_next = stable ? s3_reg : level_reg;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_reg <= 1'b0;
      end else if (ce) begin
         s1_reg <= raw_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
      end
   end
   assign level = level_reg;
   assign rise = ce & level_next & ~level_reg;
   assign fall = ce & ~level_next & level_reg;
endmodule // sync_edge

// ### design/rate_divider.sv
// divides a stream of enable pulses by a fixed ratio
module rate_divider #(
   parameter int DIV = 12
) (
   // clock and control
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // pulses in and out
   input wire logic en,
   output logic pulse
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_reg;
   wire logic [W-1:0] cnt_next = (cnt_reg == LAST) ? '0 : W'(cnt_reg + 1'b1);
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else if (ce && en) begin
         cnt_reg <= cnt_next;
      end
   end
   assign pulse = ce & en & (cnt_reg == LAST);
endmodule // rate_divider

// ### design/counter_array_core.sv
// programmable counter array: shared counter, six capture/compare modules
//
// Contract
// - low read snapshots high; reads never disturb
// - three-bit selector picks counter timebase
// - count falling edges of external input
// - oscillator divide-by-eight synchronised first
// - counter wrap sets overflow flag
// - overflow irq only when enabled
// - overflow flag cleared only by software
// - counter runs in idle unless suspended
// - eight flags set regardless of enables
// - cycle overflow at selected bit, gated
// - one irq from flags and enables
// - bits five/four select capture edges
// - bits three/two/one select compare modes
// - bit one without seven: short pwm
// - bits seven and one: sixteen-bit pwm
// - comparator off stops toggle, pwm low
// - one shared pwm cycle length
// - select bit steers compare or reload
// - pwm match sets flag when enabled
// - capture copies counter and sets flag
// - capture flag cleared only by software
// - pulses under two cycles ignored
// - low write clears, high sets comparator
module counter_array_core
   import cnt_array_pkg::*;
#(
   parameter int NMOD = cnt_array_pkg::NUM_MODULES
) (
   // clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic ce,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // timebase sources and processor state
   input wire logic ext_count_input,
   input wire logic ext_osc_in,
   input wire logic timer0_ovf,
   input wire logic cpu_idle,
   // module i/o lines
   input wire logic [NMOD-1:0] module_io_line_in,
   output logic [NMOD-1:0] module_io_line_out,
   output logic [NMOD-1:0] module_io_line_oe,
   // interrupt request
   output logic irq_req
);
   import cnt_array_pkg::*;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire logic wr = ce & sfr_wr;
   wire logic rd = ce & sfr_rd;
   wire logic [2:0] idx = sfr_addr[2:0];
   wire logic idx_ok = (idx < 3'(NMOD));
   wire logic sel_ctrl = (sfr_addr == ADDR_CTRL);
   wire logic sel_mode = (sfr_addr == ADDR_MODE);
   wire logic sel_pwm = (sfr_addr == ADDR_PWM);
   wire logic sel_lo = (sfr_addr == ADDR_CNT_LO);
   wire logic sel_hi = (sfr_addr == ADDR_CNT_HI);
   wire logic sel_mm = (sfr_addr[7:3] == BASE_MMODE) & idx_ok;
   wire logic sel_cl = (sfr_addr[7:3] == BASE_CMP_LO) & idx_ok;
   wire logic sel_ch = (sfr_addr[7:3] == BASE_CMP_HI) & idx_ok;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic [7:0] mode_reg, pwm_reg;
   logic cf_reg, run_reg, cycle_overflow_flag_reg;
   logic [NMOD-1:0] ccf_reg;
   logic [15:0] cnt_reg;
   logic [7:0] snap_reg, rdata_reg;
   logic irq_reg;
   wire logic idle_suspend = mode_reg[MODE_IDLE];
   wire logic [2:0] timebase_select = mode_reg[MODE_TB_LSB +: 3];
   wire logic overflow_irq_enable = mode_reg[MODE_OVF_EN];
   wire logic reload_access_select = pwm_reg[PWM_ARS];
   wire logic cycle_overflow_irq_enable = pwm_reg[PWM_COV_EN];
   wire logic [1:0] cycle_length_select = pwm_reg[1:0];

   // ----------------------------------------
   // timebase
   // ----------------------------------------
   logic eci_fall, osc_rise, div12_p, div4_p, osc8_p;
   sync_edge u_eci (.core_clk(core_clk), .nrst(nrst), .ce(ce), .raw_in(ext_count_input),
      .level(), .rise(), .fall(eci_fall));
   sync_edge u_osc (.core_clk(core_clk), .nrst(nrst), .ce(ce), .raw_in(ext_osc_in),
      .level(), .rise(osc_rise), .fall());
   rate_divider #(.DIV(DIV_SYS12)) u_div12 (.core_clk(core_clk), .nrst(nrst), .ce(ce),
      .en(1'b1), .pulse(div12_p));
   rate_divider #(.DIV(DIV_SYS4)) u_div4 (.core_clk(core_clk), .nrst(nrst), .ce(ce),
      .en(1'b1), .pulse(div4_p));
   rate_divider #(.DIV(DIV_OSC8)) u_div8 (.core_clk(core_clk), .nrst(nrst), .ce(ce),
      .en(osc_rise), .pulse(osc8_p));
   wire logic base_tick =
      (timebase_select == TB_DIV12) ? div12_p :
      (timebase_select == TB_DIV4) ? div4_p :
      (timebase_select == TB_T0OVF) ? (ce & timer0_ovf) :
      (timebase_select == TB_EXTIN) ? eci_fall :
      (timebase_select == TB_SYS) ? ce :
      (timebase_select == TB_OSC8) ? osc8_p : 1'b0;
   wire logic tick = run_reg & base_tick & ~(idle_suspend & cpu_idle);

   // ----------------------------------------
   // counter and overflow events
   // ----------------------------------------
   wire logic [15:0] cnt_inc = 16'(cnt_reg + 16'h0001);
   wire logic cnt_wrap = tick & (cnt_reg == 16'hffff);
   wire logic cyc_ovf = tick & (&cnt_reg[7:0]) & ((cycle_length_select == 2'b00) |
      (cnt_reg[8] & ((cycle_length_select == 2'b01) |
      (cnt_reg[9] & ((cycle_length_select == 2'b10) | cnt_reg[10])))));
   wire logic [15:0] pwm_mask = 16'(PWM_MASK_11 >> (2'd3 - cycle_length_select));
   wire logic [15:0] cnt_next =
      (wr & sel_lo) ? {cnt_reg[15:8], sfr_wdata} :
      (wr & sel_hi) ? {sfr_wdata, cnt_reg[7:0]} :
      tick ? cnt_inc : cnt_reg;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         cnt_reg <= RST_CNT;
         snap_reg <= 8'h00;
      end else if (ce) begin
         cnt_reg <= cnt_next;
         if (rd & sel_lo) begin
            snap_reg <= cnt_reg[15:8];
         end
      end
   end

   // ----------------------------------------
   // capture/compare modules
   // ----------------------------------------
   logic [7:0] mm_reg [NMOD];
   logic [15:0] cmp_reg [NMOD];
   logic [15:0] rel_reg [NMOD];
   logic [NMOD-1:0] ccf_set, out_reg, oe_reg, cap_evt;
   genvar g;
   generate
      for (g = 0; g < NMOD; g++) begin : ch
         logic io_rise, io_fall;
         sync_edge u_io (.core_clk(core_clk), .nrst(nrst), .ce(ce),
            .raw_in(module_io_line_in[g]), .level(), .rise(io_rise),
            .fall(io_fall));
         wire logic [7:0] m = mm_reg[g];
         wire logic ecom = m[MM_ECOM];
         wire logic mat = m[MM_MATCH];
         wire logic cap_mode = (m[3:1] == 3'b000) & (m[MM_RISE] | m[MM_FALL]);
         wire logic tmr_mode = (m[3:1] == 3'b100);
         wire logic hso_mode = (m[3:1] == 3'b110);
         wire logic frq_mode = (m[3:1] == 3'b011);
         wire logic pwm_mode = m[MM_PULSE] & ~m[MM_TOGGLE];
         wire logic pwm16 = pwm_mode & m[MM_PWM16];
         wire logic pulse_mod_enable = pwm_mode & ~m[MM_PWM16];
         wire logic [15:0] c = cmp_reg[g];
         wire logic m16 = tick & (cnt_inc == c);
         wire logic m8 = tick & (cnt_inc[7:0] == c[7:0]);
         wire logic mn = tick & ((cnt_inc & pwm_mask) == (c & pwm_mask));
         wire logic hit = ecom & (((tmr_mode | hso_mode | pwm16) & m16) |
            (frq_mode & m8) | (pulse_mod_enable & mn));
         wire logic pwm_end = pulse_mod_enable ? cyc_ovf : cnt_wrap;
         wire logic wr_lo = wr & sel_cl & (idx == 3'(g));
         wire logic wr_hi = wr & sel_ch & (idx == 3'(g));
         assign cap_evt[g] = cap_mode & ((m[MM_RISE] & io_rise) | (m[MM_FALL] & io_fall));
         assign ccf_set[g] = cap_evt[g] | (mat & hit & (tmr_mode | hso_mode | pwm_mode)) |
            (frq_mode & mat & m16);
         wire logic out_next =
            ((hso_mode | frq_mode) & hit) ? ~out_reg[g] :
            (pwm_mode & ~ecom) ? 1'b0 :
            (pwm_mode & hit) ? 1'b1 :
            (pwm_mode & pwm_end) ? 1'b0 : out_reg[g];
         wire logic [15:0] cmp_next =
            (wr_lo & ~reload_access_select) ? {c[15:8], sfr_wdata} :
            (wr_hi & ~reload_access_select) ? {sfr_wdata, c[7:0]} :
            cap_evt[g] ? (tick ? cnt_inc : cnt_reg) :
            (frq_mode & hit) ? {c[15:8], 8'(c[7:0] + c[15:8])} :
            (pulse_mod_enable & cyc_ovf & (cycle_length_select == 2'b00)) ? {c[15:8], c[15:8]} :
            (pulse_mod_enable & cyc_ovf) ? rel_reg[g] : c;
         wire logic [7:0] mm_next =
            (wr & sel_mm & (idx == 3'(g))) ? sfr_wdata :
            wr_lo ? (m & ~(8'h01 << MM_ECOM)) :
            wr_hi ? (m | (8'h01 << MM_ECOM)) : m;
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               mm_reg[g] <= RST_MMODE;
               cmp_reg[g] <= 16'h0000;
               rel_reg[g] <= 16'h0000;
               out_reg[g] <= 1'b0;
               oe_reg[g] <= 1'b0;
            end else if (ce) begin
               mm_reg[g] <= mm_next;
               cmp_reg[g] <= tick | wr_lo | wr_hi | cap_evt[g] ? cmp_next : c;
               if (wr_lo & reload_access_select) begin
                  rel_reg[g][7:0] <= sfr_wdata;
               end
               if (wr_hi & reload_access_select) begin
                  rel_reg[g][15:8] <= sfr_wdata;
               end
               out_reg[g] <= out_next;
               oe_reg[g] <= hso_mode | frq_mode | pwm_mode;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // flags and interrupt
   // ----------------------------------------
   wire logic wr_ctrl = wr & sel_ctrl;
   wire logic wr_pwm = wr & sel_pwm;
   wire logic cf_next = cnt_wrap | (wr_ctrl ? sfr_wdata[CTRL_CF] : cf_reg);
   wire logic cycle_overflow_flag_next = cyc_ovf | (wr_pwm ? sfr_wdata[PWM_CYCLE_OVERFLOW_FLAG] : cycle_overflow_flag_reg);
   wire logic [NMOD-1:0] ccf_next = ccf_set |
      (wr_ctrl ? sfr_wdata[NMOD-1:0] : ccf_reg);
   logic [NMOD-1:0] mod_ie;
   always_comb begin
      for (int i = 0; i < NMOD; i++) begin
         mod_ie[i] = mm_reg[i][MM_IRQ_EN];
      end
   end
   wire logic irq_any = (cf_reg & overflow_irq_enable) |
      (cycle_overflow_flag_reg & cycle_overflow_irq_enable) | (|(ccf_reg & mod_ie));
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         mode_reg <= RST_MODE;
         pwm_reg <= RST_PWM;
         cf_reg <= RST_CTRL[CTRL_CF];
         run_reg <= RST_CTRL[CTRL_RUN];
         cycle_overflow_flag_reg <= RST_PWM[PWM_CYCLE_OVERFLOW_FLAG];
         ccf_reg <= '0;
         irq_reg <= 1'b0;
      end else if (ce) begin
         if (wr & sel_mode) begin
            mode_reg <= sfr_wdata;
         end
         if (wr_pwm) begin
            pwm_reg <= sfr_wdata;
         end
         if (wr_ctrl) begin
            run_reg <= sfr_wdata[CTRL_RUN];
         end
         cf_reg <= cf_next;
         cycle_overflow_flag_reg <= cycle_overflow_flag_next;
         ccf_reg <= ccf_next;
         irq_reg <= irq_any;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   wire logic [15:0] cmp_sel = idx_ok ? cmp_reg[idx] : 16'h0000;
   wire logic [15:0] rel_sel = idx_ok ? rel_reg[idx] : 16'h0000;
   wire logic [15:0] cc_view = reload_access_select ? rel_sel : cmp_sel;
   wire logic [7:0] rd_mux =
      sel_ctrl ? {cf_reg, run_reg, 6'(ccf_reg)} :
      sel_mode ? {idle_suspend, 3'b000, timebase_select, overflow_irq_enable} :
      sel_pwm ? {reload_access_select, cycle_overflow_irq_enable, cycle_overflow_flag_reg, 3'b000,
         cycle_length_select} :
      sel_lo ? cnt_reg[7:0] :
      sel_hi ? snap_reg :
      sel_mm ? mm_reg[idx] :
      sel_cl ? cc_view[7:0] :
      sel_ch ? cc_view[15:8] : 8'h00;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rdata_reg <= 8'h00;
      end else if (rd) begin
         rdata_reg <= rd_mux;
      end
   end
   assign sfr_rdata = rdata_reg;
   assign module_io_line_out = out_reg;
   assign module_io_line_oe = oe_reg;
   assign irq_req = irq_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_snap_latch: assert property (rd & sel_lo |=> snap_reg == $past(cnt_reg[15:8]))
      else $error("snapshot not taken on low read");
   a_read_keeps_count: assert property (rd & ~wr & ~tick |=> cnt_reg == $past(cnt_reg))
      else $error("read disturbed counter");
   a_reserved_tb: assert property (timebase_select[2:1] == 2'b11 |-> !base_tick)
      else $error("reserved timebase advanced counter");
   a_ovf_flag: assert property (cnt_wrap & ~wr |=> cf_reg && cnt_reg == 16'h0000)
      else $error("wrap did not set overflow flag");
   a_flag_sticky: assert property (cf_reg & ce & ~wr_ctrl |=> cf_reg)
      else $error("overflow flag cleared by hardware");
   a_irq_gate: assert property (ce & cf_reg & !overflow_irq_enable & !cycle_overflow_flag_reg & ~|ccf_reg
      |=> !irq_req)
      else $error("irq without enable");
   a_idle_run: assert property (run_reg & cpu_idle & !idle_suspend |-> tick == base_tick)
      else $error("counter stopped in idle");
   a_cov_flag: assert property (cyc_ovf |=> cycle_overflow_flag_reg)
      else $error("cycle overflow flag not set");
   a_cmp_low_clr: assert property (wr & sel_cl & idx == 3'd3 & ~sel_mm
      |=> !mm_reg[3][MM_ECOM])
      else $error("low compare write did not clear enable");
   a_cmp_high_set: assert property (wr & sel_ch & idx == 3'd3 |=> mm_reg[3][MM_ECOM])
      else $error("high compare write did not set enable");
   a_capture_val: assert property (cap_evt[0] & ~wr |=> cmp_reg[0] == cnt_reg
      && ccf_reg[0])
      else $error("capture did not load counter");
   a_pwm_off: assert property (ce & ch[4].pwm_mode & !ch[4].ecom |=> !out_reg[4])
      else $error("pwm output high with comparator off");
   c_capture: cover property (cap_evt[0]);
   c_wrap: cover property (cnt_wrap);
   c_pwm_high: cover property (ch[2].pwm_mode & out_reg[2]);
   c_irq: cover property (irq_req);
endmodule // counter_array_core

// ### dv/pin_partner.sv
// host-side pin model: external count source and module input lines
module pin_partner (
   // clock
   input wire logic core_clk,
   // driven lines
   output logic ext_count_input,
   output logic [5:0] module_io_line_in
);
   timeunit 1ns;
   timeprecision 100ps;
   int ph = 0;
   initial begin
      ext_count_input = 1'b1;
      module_io_line_in = 6'h00;
   end
   // falling edge every eight cycles, below a quarter of the clock
   always @(posedge core_clk) begin
      #2;
      ph = (ph + 1) % 8;
      ext_count_input = (ph < 4);
   end
   // pin pulse of w cycles; under two cycles only when a test asks
   task automatic pulse(input int n, input int w);
      @(posedge core_clk);
      #2 module_io_line_in[n] = 1'b1;
      repeat (w) @(posedge core_clk);
      #2 module_io_line_in[n] = 1'b0;
   endtask
endmodule // pin_partner

// ### dv/programmable_counter_array_core_tb.sv
// self-checking bench for the counter array core
module programmable_counter_array_core_tb import cnt_array_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic ext_count_input;
   logic ext_osc_in = 1'b0;
   logic timer0_ovf = 1'b0;
   logic cpu_idle = 1'b0;
   logic [5:0] module_io_line_in;
   logic [5:0] module_io_line_out;
   logic [5:0] module_io_line_oe;
   logic irq_req;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int t0c = 0;
   logic [15:0] v16;
   timebase_t tbs [7] = '{TB_DIV12, TB_DIV4, TB_T0OVF, TB_EXTIN, TB_SYS, TB_OSC8, TB_SYS};
   int exp_n [7] = '{16, 48, 24, 24, 193, 6, 193};
   // ----------------------------------------
   // design, partner and sources
   // ----------------------------------------
   counter_array_core #(.NMOD(6)) dut (.core_clk(core_clk), .nrst(nrst), .ce(1'b1),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .ext_count_input(ext_count_input), .ext_osc_in(ext_osc_in),
      .timer0_ovf(timer0_ovf), .cpu_idle(cpu_idle), .module_io_line_in(module_io_line_in),
      .module_io_line_out(module_io_line_out), .module_io_line_oe(module_io_line_oe),
      .irq_req(irq_req));
   pin_partner pins (.core_clk(core_clk), .ext_count_input(ext_count_input),
      .module_io_line_in(module_io_line_in));
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      #2;
      timer0_ovf = (t0c % 8 == 0);
      ext_osc_in = (t0c % 4 < 2);
      t0c++;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         test_done();
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic near(input string name, input logic [15:0] seen, input int lo, input int hi);
      check(name, {15'h0000, (seen >= lo) && (seen <= hi)}, 16'h0001);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #2;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge core_clk);
      #2 sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #2;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge core_clk);
      #2 sfr_rd = 1'b0;
      @(posedge core_clk);
      #2 d = sfr_rdata;
   endtask
   task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check(name, {8'h00, d}, {8'h00, e});
   endtask
   task automatic rd16(output logic [15:0] v);
      rd(ADDR_CNT_LO, v[7:0]);
      rd(ADDR_CNT_HI, v[15:8]);
   endtask
   task automatic setcnt(input logic [15:0] v);
      wr(ADDR_CNT_LO, v[7:0]);
      wr(ADDR_CNT_HI, v[15:8]);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      cyc(6);
      #2 nrst = 1'b1;
      // reset values and an unmapped place
      wr(8'h07, 8'hff);
      rdchk("control", ADDR_CTRL, RST_CTRL);
      rdchk("mode", ADDR_MODE, RST_MODE);
      rdchk("pwm control", ADDR_PWM, RST_PWM);
      rdchk("module mode", {BASE_MMODE, 3'd0}, RST_MMODE);
      rdchk("unmapped", 8'h07, 8'h00);
      $display("test reset done");
      // snapshot holds high byte while counting goes on
      wr(ADDR_MODE, 8'h08);
      setcnt(16'h10f0);
      wr(ADDR_CTRL, 8'h40);
      rd(ADDR_CNT_LO, v16[7:0]);
      cyc(40);
      rdchk("snapshot", ADDR_CNT_HI, 8'h10);
      rd16(v16);
      check("count high", {8'h00, v16[15:8]}, 16'h0011);
      $display("test snapshot done");
      // timebase table, last entry with processor idle
      for (int i = 0; i < 7; i++) begin
         cpu_idle = (i == 6);
         wr(ADDR_MODE, {4'h0, tbs[i], 1'b0});
         setcnt(16'h0000);
         wr(ADDR_CTRL, 8'h40);
         cyc(192);
         wr(ADDR_CTRL, 8'h00);
         rd16(v16);
         near("timebase count", v16, exp_n[i] - 3, exp_n[i] + 3);
      end
      cpu_idle = 1'b0;
      wr(ADDR_MODE, {4'h0, TB_RES6, 1'b0});
      setcnt(16'h0000);
      wr(ADDR_CTRL, 8'h40);
      cyc(20);
      rd16(v16);
      check("reserved timebase", v16, 16'h0000);
      wr(ADDR_CTRL, 8'h00);
      $display("test timebase done");
      // counter wrap, overflow flag and its interrupt
      wr(ADDR_MODE, 8'h09);
      setcnt(16'hfff0);
      wr(ADDR_CTRL, 8'h40);
      cyc(30);
      rdchk("overflow flag", ADDR_CTRL, 8'hc0);
      check("irq enabled", {15'h0000, irq_req}, 16'h0001);
      wr(ADDR_MODE, 8'h08);
      cyc(3);
      check("irq masked", {15'h0000, irq_req}, 16'h0000);
      rdchk("flag kept", ADDR_CTRL, 8'hc0);
      wr(ADDR_CTRL, 8'h00);
      rdchk("flag cleared", ADDR_CTRL, 8'h00);
      $display("test overflow done");
      // cycle overflow at the selected bit
      wr(ADDR_PWM, 8'h41);
      setcnt(16'h00f0);
      wr(ADDR_CTRL, 8'h40);
      cyc(30);
      wr(ADDR_CTRL, 8'h00);
      rdchk("no cycle overflow", ADDR_PWM, 8'h41);
      setcnt(16'h01f0);
      wr(ADDR_CTRL, 8'h40);
      cyc(30);
      wr(ADDR_CTRL, 8'h00);
      rdchk("cycle overflow", ADDR_PWM, 8'h61);
      check("cycle irq", {15'h0000, irq_req}, 16'h0001);
      wr(ADDR_PWM, 8'h01);
      cyc(3);
      check("cycle irq off", {15'h0000, irq_req}, 16'h0000);
      $display("test cycle overflow done");
      // edge capture, short pulse ignored
      wr(ADDR_MODE, 8'h00);
      setcnt(16'h1234);
      wr({BASE_MMODE, 3'd0}, 8'h21);
      wr({BASE_MMODE, 3'd1}, 8'h11);
      wr(ADDR_CTRL, 8'h40);
      pins.pulse(0, 1);
      cyc(8);
      rdchk("short pulse", ADDR_CTRL, 8'h40);
      pins.pulse(0, 4);
      cyc(8);
      rdchk("rise capture", ADDR_CTRL, 8'h41);
      check("capture irq", {15'h0000, irq_req}, 16'h0001);
      pins.pulse(1, 4);
      cyc(8);
      rdchk("fall capture", ADDR_CTRL, 8'h43);
      rd({BASE_CMP_LO, 3'd0}, v16[7:0]);
      rd({BASE_CMP_HI, 3'd0}, v16[15:8]);
      near("captured count", v16, 16'h1234, 16'h1237);
      wr(ADDR_CTRL, 8'h00);
      rdchk("capture flags cleared", ADDR_CTRL, 8'h00);
      $display("test capture done");
      // compare byte writes steer comparator enable and reload access
      wr({BASE_MMODE, 3'd3}, 8'h48);
      wr({BASE_CMP_LO, 3'd3}, 8'h00);
      rdchk("low write", {BASE_MMODE, 3'd3}, 8'h08);
      wr({BASE_CMP_HI, 3'd3}, 8'h20);
      rdchk("high write", {BASE_MMODE, 3'd3}, 8'h48);
      wr(ADDR_PWM, 8'h80);
      wr({BASE_CMP_LO, 3'd5}, 8'haa);
      wr(ADDR_PWM, 8'h00);
      rdchk("compare side", {BASE_CMP_LO, 3'd5}, 8'h00);
      wr(ADDR_PWM, 8'h80);
      rdchk("reload side", {BASE_CMP_LO, 3'd5}, 8'haa);
      wr(ADDR_PWM, 8'h00);
      // software timer match and disabled sixteen-bit pwm
      wr(ADDR_MODE, 8'h08);
      wr({BASE_MMODE, 3'd4}, 8'h82);
      setcnt(16'h1ff0);
      wr(ADDR_CTRL, 8'h40);
      cyc(30);
      rdchk("timer match", ADDR_CTRL, 8'h48);
      check("pwm pin driven", {15'h0000, module_io_line_oe[4]}, 16'h0001);
      check("pwm pin low", {15'h0000, module_io_line_out[4]}, 16'h0000);
      wr(ADDR_CTRL, 8'h00);
      // eight-bit pwm and high-speed output on one compare match
      wr({BASE_MMODE, 3'd2}, 8'h0a);
      wr({BASE_CMP_LO, 3'd2}, 8'h80);
      wr({BASE_CMP_HI, 3'd2}, 8'h80);
      wr({BASE_MMODE, 3'd5}, 8'h0c);
      wr({BASE_CMP_LO, 3'd5}, 8'h80);
      wr({BASE_CMP_HI, 3'd5}, 8'h00);
      setcnt(16'h0070);
      wr(ADDR_CTRL, 8'h40);
      cyc(30);
      rdchk("pwm and toggle match", ADDR_CTRL, 8'h64);
      check("pwm pin high", {15'h0000, module_io_line_out[2]}, 16'h0001);
      check("toggle pin high", {15'h0000, module_io_line_out[5]}, 16'h0001);
      wr(ADDR_CTRL, 8'h00);
      $display("test compare done");
      test_done();
   end
endmodule // programmable_counter_array_core_tb
